// file: core/spad_defs.vh
`ifndef SPAD_DEFS_VH
`define SPAD_DEFS_VH

// register byte offsets on the control bus
`define REG_CMD 8'h00
`define REG_INDEX 8'h04
`define REG_PADDR 8'h08
`define REG_WDATA 8'h0C
`define REG_BYTEEN 8'h10
`define REG_TAG_LOW_REGISTER 8'h14
`define REG_DRDATA 8'h18
`define REG_IRDATA 8'h1C
`define REG_STATUS 8'h20

// command register fields
`define CMD_PORT_BIT 0
`define CMD_OP_HI 2
`define CMD_OP_LO 1
`define PORT_DATA 1'b0
`define PORT_INSTR 1'b1

// access kinds
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_TAGRD 2'h2
`define OP_TAGWR 2'h3

// physical address register fields
`define PADDR_HI 31
`define PADDR_LO 10
`define PADDR_UNC_BIT 0

// reset values
`define BYTEEN_RESET 4'hF
`define WORD_RESET 32'h00000000
`define TAG_RESET 24'h000000

// status register bits
`define ST_DBUSY 0
`define ST_DDONE 1
`define ST_DHIT 2
`define ST_DABSENT 3
`define ST_IBUSY 4
`define ST_IDONE 5
`define ST_IHIT 6
`define ST_IABSENT 7
`define ST_DPRESENT 8
`define ST_IPRESENT 9

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: core/spad_sync2.v
module spad_sync2 #(
    parameter W = 2
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // levels from outside the clock domain
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_sync
            reg meta_ff;
            reg safe_ff;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    meta_ff <= 1'b0;
                    safe_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[g];
                    safe_ff <= meta_ff;
                end
            end
            assign sync_out[g] = safe_ff;
        end
    endgenerate

endmodule

// file: core/spad_access_seq.v
`include "spad_defs.vh"

module spad_access_seq (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // command side
    input wire start,
    input wire [1:0] op,
    input wire present,
    output wire busy,
    output reg done_ff,
    output reg refused_ff,
    output reg hit_ff,
    output reg [31:0] word_ff,
    output reg [23:0] tag_ff,
    // strobes toward the array
    output reg data_rd_ff,
    output reg tag_rd_ff,
    output reg data_wr_ff,
    output reg tag_wr_ff,
    // answers from the array, same clock
    input wire stall,
    input wire hit,
    input wire [31:0] read_word,
    input wire [23:0] tag_value
);

    localparam S_IDLE = 3'b001;
    localparam S_READ = 3'b010;
    localparam S_WRITE = 3'b100;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;

    wire is_read = (op == `OP_READ) || (op == `OP_TAGRD);

    assign busy = (state_ff != S_IDLE);

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (start && present) begin
                    nxt_state = is_read ? S_READ : S_WRITE;
                end
            end
            S_READ: begin
                if (!stall) begin
                    nxt_state = S_IDLE;
                end
            end
            S_WRITE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= S_IDLE;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            hit_ff <= 1'b0;
            word_ff <= `WORD_RESET;
            tag_ff <= `TAG_RESET;
            data_rd_ff <= 1'b0;
            tag_rd_ff <= 1'b0;
            data_wr_ff <= 1'b0;
            tag_wr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (start && !present) begin
                        done_ff <= 1'b1;
                        refused_ff <= 1'b1;
                    end else if (start) begin
                        data_rd_ff <= (op == `OP_READ);
                        tag_rd_ff <= is_read;
                        data_wr_ff <= (op == `OP_WRITE);
                        tag_wr_ff <= (op == `OP_TAGWR);
                    end
                end
                S_READ: begin
                    // answers are sampled in the strobe cycle itself, no stage between
                    if (!stall) begin
                        data_rd_ff <= 1'b0;
                        tag_rd_ff <= 1'b0;
                        hit_ff <= hit;
                        // a miss leaves the word to the normal cache path
                        word_ff <= hit ? read_word : `WORD_RESET;
                        tag_ff <= tag_value;
                        done_ff <= 1'b1;
                    end
                end
                S_WRITE: begin
                    data_wr_ff <= 1'b0;
                    tag_wr_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                default: begin
                    data_rd_ff <= 1'b0;
                    tag_rd_ff <= 1'b0;
                    data_wr_ff <= 1'b0;
                    tag_wr_ff <= 1'b0;
                end
            endcase
        end
    end

endmodule

// file: core/scratchpad_ram_port.v
// Notes on behaviour
// - port pins are driven and sampled directly so an access ends in its first cycle without stall.
// - data tag read strobe qualifies lookup; hit, stall, tag value follow it.
// - on either port a tag write strobe makes the array store the supplied tag.
// - data write gives 32-bit word and 4 byte enables; only enabled bytes change.
// - data write strobe marks the single cycle in which the array is written.
// - data read strobe requests a read; array returns a 32-bit word.
// - returned tag value, address, lock, valid, loads tag low on a tag read.
// - array raises hit when the read address lies inside its covered region.
// - array holds stall until the read completes; results are used only afterwards.
// - each port is used only while its presence input shows an attached array.
// - instruction read strobe reads tag and data together; hit, stall follow it.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`include "spad_defs.vh"

module scratchpad_ram_port (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control bus, write address
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    // control bus, write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // control bus, write response
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // control bus, read address
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    // control bus, read data
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // data scratchpad port
    output wire [19:4] dport_tag_index,
    output wire dport_tag_read_strobe,
    output wire dport_tag_write_strobe,
    output wire [23:0] dport_tag_compare_bus,
    output wire [19:2] dport_word_index,
    output wire [31:0] dport_write_word,
    output wire dport_data_read_strobe,
    output wire dport_data_write_strobe,
    output wire [3:0] dport_byte_enables,
    input wire [31:0] dport_read_word,
    input wire [23:0] dport_tag_read_value,
    input wire dport_hit,
    input wire dport_stall,
    input wire dport_present,
    // instruction scratchpad port
    output wire [19:2] iport_index,
    output wire iport_read_strobe,
    output wire iport_tag_write_strobe,
    output wire iport_data_write_strobe,
    output wire [31:0] iport_write_compare_bus,
    input wire [31:0] iport_read_word,
    input wire [23:0] iport_tag_read_value,
    input wire iport_hit,
    input wire iport_stall,
    input wire iport_present
);

    // software registers
    reg [2:0] cmd_ff;
    reg [31:0] index_ff;
    reg [31:0] paddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] byteen_ff;
    reg [23:0] tag_low_register_ff;
    reg [31:0] drdata_ff;
    reg [31:0] irdata_ff;
    reg ddone_ff;
    reg dabsent_ff;
    reg idone_ff;
    reg iabsent_ff;
    reg dhit_ff;
    reg ihit_ff;

    // values held on the pins for the whole access
    reg [19:2] dindex_ff;
    reg [19:2] iindex_ff;
    reg [23:0] dbus_ff;
    reg [31:0] ibus_ff;
    reg [31:0] dword_ff;
    reg [3:0] dbe_ff;
    reg [1:0] dop_ff;
    reg [1:0] iop_ff;

    // bus slave state
    reg aw_got_ff;
    reg w_got_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wbus_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;
    reg [1:0] nxt_bresp;

    wire [1:0] present_sync;
    wire d_busy;
    wire i_busy;
    wire d_done;
    wire i_done;
    wire d_refused;
    wire i_refused;
    wire d_hit;
    wire i_hit;
    wire [31:0] d_word;
    wire [31:0] i_word;
    wire [23:0] d_tag;
    wire [23:0] i_tag;
    wire i_data_rd;
    wire i_tag_rd;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[8*k +: 8] = nw[8*k +: 8];
                end
            end
        end
    endfunction

    wire [31:0] tag_low_register_merged = merge({8'h00, tag_low_register_ff}, wbus_ff, wstrb_ff);

    // write side: address and data are taken in either order, then applied together
    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready = !w_got_ff && !bvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = !rvalid_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    wire wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wire wr_cmd = wr_fire && (awaddr_ff == `REG_CMD) && wstrb_ff[0];
    wire [1:0] wr_op = wbus_ff[`CMD_OP_HI:`CMD_OP_LO];
    wire wr_port = wbus_ff[`CMD_PORT_BIT];
    // a port that is still busy refuses a new command, the other one is unaffected
    wire d_start = wr_cmd && (wr_port == `PORT_DATA) && !d_busy;
    wire i_start = wr_cmd && (wr_port == `PORT_INSTR) && !i_busy;
    wire cmd_refused = wr_cmd && !d_start && !i_start;

    always @* begin
        nxt_bresp = `RESP_OKAY;
        case (awaddr_ff)
            `REG_CMD: nxt_bresp = cmd_refused ? `RESP_SLVERR : `RESP_OKAY;
            `REG_INDEX, `REG_PADDR, `REG_WDATA, `REG_BYTEEN, `REG_TAG_LOW_REGISTER,
            `REG_DRDATA, `REG_IRDATA, `REG_STATUS: nxt_bresp = `RESP_OKAY;
            default: nxt_bresp = `RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wbus_ff <= `WORD_RESET;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wbus_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= nxt_bresp;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read side has no side effects
    wire [31:0] status_word = {22'h000000, present_sync[1], present_sync[0],
                               iabsent_ff, ihit_ff, idone_ff, i_busy,
                               dabsent_ff, dhit_ff, ddone_ff, d_busy};

    always @* begin
        nxt_rresp = `RESP_OKAY;
        nxt_rdata = `WORD_RESET;
        case (araddr)
            `REG_CMD: nxt_rdata = {29'h00000000, cmd_ff};
            `REG_INDEX: nxt_rdata = index_ff;
            `REG_PADDR: nxt_rdata = paddr_ff;
            `REG_WDATA: nxt_rdata = wdata_ff;
            `REG_BYTEEN: nxt_rdata = {28'h0000000, byteen_ff};
            `REG_TAG_LOW_REGISTER: nxt_rdata = {8'h00, tag_low_register_ff};
            `REG_DRDATA: nxt_rdata = drdata_ff;
            `REG_IRDATA: nxt_rdata = irdata_ff;
            `REG_STATUS: nxt_rdata = status_word;
            default: nxt_rresp = `RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `RESP_OKAY;
            rdata_ff <= `WORD_RESET;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // register file and result capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ff <= 3'h0;
            index_ff <= `WORD_RESET;
            paddr_ff <= `WORD_RESET;
            wdata_ff <= `WORD_RESET;
            byteen_ff <= `BYTEEN_RESET;
            tag_low_register_ff <= `TAG_RESET;
            drdata_ff <= `WORD_RESET;
            irdata_ff <= `WORD_RESET;
            ddone_ff <= 1'b0;
            dabsent_ff <= 1'b0;
            idone_ff <= 1'b0;
            iabsent_ff <= 1'b0;
            dhit_ff <= 1'b0;
            ihit_ff <= 1'b0;
        end else begin
            if (wr_fire) begin
                case (awaddr_ff)
                    `REG_CMD: cmd_ff <= (d_start || i_start) ? wbus_ff[2:0] : cmd_ff;
                    `REG_INDEX: index_ff <= merge(index_ff, wbus_ff, wstrb_ff);
                    `REG_PADDR: paddr_ff <= merge(paddr_ff, wbus_ff, wstrb_ff);
                    `REG_WDATA: wdata_ff <= merge(wdata_ff, wbus_ff, wstrb_ff);
                    `REG_BYTEEN: byteen_ff <= wstrb_ff[0] ? wbus_ff[3:0] : byteen_ff;
                    `REG_TAG_LOW_REGISTER: tag_low_register_ff <= tag_low_register_merged[23:0];
                    default: cmd_ff <= cmd_ff;
                endcase
            end
            // a finished tag read overrides a software write in the same cycle
            if (d_done && !d_refused && dop_ff == `OP_TAGRD) begin
                tag_low_register_ff <= d_tag;
            end else if (i_done && !i_refused && iop_ff == `OP_TAGRD) begin
                tag_low_register_ff <= i_tag;
            end
            if (d_done && !d_refused) begin
                drdata_ff <= d_word;
                dhit_ff <= d_hit;
            end
            if (i_done && !i_refused) begin
                irdata_ff <= i_word;
                ihit_ff <= i_hit;
            end
            // completion sets win over the clear made by a new command
            ddone_ff <= d_done | (ddone_ff & !d_start);
            dabsent_ff <= (d_done & d_refused) | (dabsent_ff & !d_start);
            idone_ff <= i_done | (idone_ff & !i_start);
            iabsent_ff <= (i_done & i_refused) | (iabsent_ff & !i_start);
        end
    end

    // pin values are frozen at launch and held while the array stalls
    always @(posedge aclk) begin
        if (!aresetn) begin
            dindex_ff <= 18'h00000;
            iindex_ff <= 18'h00000;
            dbus_ff <= `TAG_RESET;
            ibus_ff <= `WORD_RESET;
            dword_ff <= `WORD_RESET;
            dbe_ff <= 4'h0;
            dop_ff <= `OP_READ;
            iop_ff <= `OP_READ;
        end else begin
            if (d_start) begin
                dop_ff <= wr_op;
                dindex_ff <= index_ff[19:2];
                dword_ff <= wdata_ff;
                dbe_ff <= byteen_ff;
                if (wr_op == `OP_TAGWR) begin
                    dbus_ff <= tag_low_register_ff;
                end else begin
                    dbus_ff <= {paddr_ff[`PADDR_HI:`PADDR_LO], 2'b00};
                end
            end
            if (i_start) begin
                iop_ff <= wr_op;
                iindex_ff <= index_ff[19:2];
                if (wr_op == `OP_WRITE) begin
                    ibus_ff <= wdata_ff;
                end else if (wr_op == `OP_TAGWR) begin
                    ibus_ff <= {8'h00, tag_low_register_ff};
                end else begin
                    ibus_ff <= {8'h00, paddr_ff[`PADDR_HI:`PADDR_LO],
                                paddr_ff[`PADDR_UNC_BIT], 1'b0};
                end
            end
        end
    end

    // presence is a strap from outside, resynchronised before use
    spad_sync2 #(
        .W(2)
    ) u_present (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({iport_present, dport_present}),
        .sync_out(present_sync)
    );

    spad_access_seq u_dseq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(d_start),
        .op(wr_op),
        .present(present_sync[0]),
        .busy(d_busy),
        .done_ff(d_done),
        .refused_ff(d_refused),
        .hit_ff(d_hit),
        .word_ff(d_word),
        .tag_ff(d_tag),
        .data_rd_ff(dport_data_read_strobe),
        .tag_rd_ff(dport_tag_read_strobe),
        .data_wr_ff(dport_data_write_strobe),
        .tag_wr_ff(dport_tag_write_strobe),
        .stall(dport_stall),
        .hit(dport_hit),
        .read_word(dport_read_word),
        .tag_value(dport_tag_read_value)
    );

    spad_access_seq u_iseq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(i_start),
        .op(wr_op),
        .present(present_sync[1]),
        .busy(i_busy),
        .done_ff(i_done),
        .refused_ff(i_refused),
        .hit_ff(i_hit),
        .word_ff(i_word),
        .tag_ff(i_tag),
        .data_rd_ff(i_data_rd),
        .tag_rd_ff(i_tag_rd),
        .data_wr_ff(iport_data_write_strobe),
        .tag_wr_ff(iport_tag_write_strobe),
        .stall(iport_stall),
        .hit(iport_hit),
        .read_word(iport_read_word),
        .tag_value(iport_tag_read_value)
    );

    // data port pins
    assign dport_tag_index = dindex_ff[19:4];
    assign dport_word_index = dindex_ff;
    assign dport_tag_compare_bus = dbus_ff;
    assign dport_write_word = dword_ff;
    assign dport_byte_enables = dbe_ff;

    // instruction port pins; one strobe reads tag and data together
    assign iport_index = iindex_ff;
    assign iport_read_strobe = i_data_rd | i_tag_rd;
    assign iport_write_compare_bus = ibus_ff;

endmodule

// file: verif/spad_array_model.sv
module spad_array_model (
    // clock and answer speed
    input wire aclk,
    input wire slow,
    // data port
    input wire [19:2] dport_word_index,
    input wire dport_tag_read_strobe,
    input wire dport_tag_write_strobe,
    input wire [23:0] dport_tag_compare_bus,
    input wire [31:0] dport_write_word,
    input wire dport_data_read_strobe,
    input wire dport_data_write_strobe,
    input wire [3:0] dport_byte_enables,
    output wire [31:0] dport_read_word,
    output wire [23:0] dport_tag_read_value,
    output wire dport_hit,
    output wire dport_stall,
    // instruction port
    input wire [19:2] iport_index,
    input wire iport_read_strobe,
    input wire iport_tag_write_strobe,
    input wire iport_data_write_strobe,
    input wire [31:0] iport_write_compare_bus,
    output wire [31:0] iport_read_word,
    output wire [23:0] iport_tag_read_value,
    output wire iport_hit,
    output wire iport_stall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] dmem [0:15];
    logic [31:0] imem [0:15];
    logic [23:0] dtag = 24'h000000;
    logic [23:0] itag = 24'h000000;
    logic dwait = 1'h0;
    wire drs = dport_data_read_strobe | dport_tag_read_strobe;
    wire dok = drs & !dport_stall;
    wire dmatch = dtag[0] && dtag[23:2] == dport_tag_compare_bus[23:2];
    wire imatch = itag[0] && itag[23:2] == iport_write_compare_bus[23:2];
    wire [3:0] da = dport_word_index[5:2];
    wire [3:0] ia = iport_index[5:2];
    // one stall cycle per read when slow, so results seen early are wrong
    assign dport_stall = drs & slow & !dwait;
    // outside a finished read the answers are inverted, never the last value
    assign dport_hit = dok ? dmatch : !dmatch;
    assign dport_read_word = dok ? dmem[da] : ~dmem[da];
    assign dport_tag_read_value = dok ? dtag : ~dtag;
    assign iport_stall = 1'h0;
    assign iport_hit = iport_read_strobe ? imatch : !imatch;
    assign iport_read_word = iport_read_strobe ? imem[ia] : ~imem[ia];
    assign iport_tag_read_value = iport_read_strobe ? itag : ~itag;
    always @(posedge aclk) begin
        dwait <= dport_stall;
        if (dport_tag_write_strobe) dtag <= dport_tag_compare_bus;
        if (iport_tag_write_strobe) itag <= iport_write_compare_bus[23:0];
        if (iport_data_write_strobe) imem[ia] <= iport_write_compare_bus;
        for (int i = 0; i < 4; i++)
            if (dport_data_write_strobe && dport_byte_enables[i])
                dmem[da][8*i+:8] <= dport_write_word[8*i+:8];
    end
endmodule

// file: verif/scratchpad_ram_port_sva.sv
module scratchpad_ram_port_sva (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // data port
    input wire [19:4] dport_tag_index,
    input wire [19:2] dport_word_index,
    input wire [23:0] dport_tag_compare_bus,
    input wire dport_tag_read_strobe,
    input wire dport_tag_write_strobe,
    input wire dport_data_read_strobe,
    input wire dport_data_write_strobe,
    input wire dport_stall,
    input wire dport_present,
    // instruction port
    input wire iport_read_strobe,
    input wire iport_tag_write_strobe,
    input wire [31:0] iport_write_compare_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire dlaunch = dport_data_read_strobe | dport_tag_read_strobe;
    dwr_pulse_a: assert property ($rose(dport_data_write_strobe)
        |=> !dport_data_write_strobe) else $error("data write strobe too long");
    cmp_zero_a: assert property (dport_tag_read_strobe
        |-> dport_tag_compare_bus[1:0] == 2'h0) else $error("compare bus low bits not zero");
    idx_tie_a: assert property (dlaunch |-> dport_tag_index == dport_word_index[19:4])
        else $error("line and word index disagree");
    hold_stall_a: assert property (dlaunch && dport_stall
        |=> dlaunch && $stable(dport_word_index)) else $error("read dropped during stall");
    rd_end_a: assert property (dport_data_read_strobe && !dport_stall
        |=> !dport_data_read_strobe) else $error("read strobe held after completion");
    rd_pair_a: assert property ($rose(dport_data_read_strobe)
        |-> dport_tag_read_strobe) else $error("data read without tag lookup");
    absent_gate_a: assert property ($rose(dlaunch | dport_data_write_strobe
        | dport_tag_write_strobe) |-> $past(dport_present, 3))
        else $error("strobe on absent port");
    itw_pulse_a: assert property (iport_tag_write_strobe |=> !iport_tag_write_strobe)
        else $error("tag write strobe too long");
    icmp_form_a: assert property (iport_read_strobe
        |-> iport_write_compare_bus[31:24] == 8'h00 && !iport_write_compare_bus[0])
        else $error("bad instruction compare bus");
    cover property (dport_data_read_strobe && dport_stall);
    cover property (dport_data_write_strobe);
    cover property (iport_read_strobe);
endmodule

// file: verif/tb_scratchpad_ram_port.sv
`include "spad_defs.vh"
module tb_scratchpad_ram_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [21:0] PA = 22'h2AB3C5;
    localparam logic [23:0] TAG = {PA, 2'h1};
    logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic dport_present = 1'h1, iport_present = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rword, st;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] resp;
    int num_errors = 0, check_count = 0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, dport_write_word, dport_read_word, iport_write_compare_bus, iport_read_word;
    wire [19:4] dport_tag_index;
    wire [19:2] dport_word_index, iport_index;
    wire [23:0] dport_tag_compare_bus, dport_tag_read_value, iport_tag_read_value;
    wire [3:0] dport_byte_enables;
    wire dport_tag_read_strobe, dport_tag_write_strobe, dport_data_read_strobe;
    wire dport_data_write_strobe, dport_hit, dport_stall, iport_read_strobe;
    wire iport_tag_write_strobe, iport_data_write_strobe, iport_hit, iport_stall;
    scratchpad_ram_port u_scratchpad_ram_port (.*);
    spad_array_model u_spad_array_model (.*);
    initial begin
        forever #5 aclk = ~aclk;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task rd(input [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rword = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask
    // launch a command, then poll status until that port reports done
    task go(input [31:0] c);
        wr(`REG_CMD, c);
        chk(resp, `RESP_OKAY);
        st = 32'h0;
        for (int i = 0; i < 9 && st[c[0] ? `ST_IDONE : `ST_DDONE] !== 1'h1; i++) begin
            rd(`REG_STATUS);
            st = rword;
        end
        chk(st[c[0] ? `ST_IDONE : `ST_DDONE], 1'h1);
    endtask
    task t_regs;
        rd(`REG_BYTEEN);
        chk(rword, 32'h0000000F);
        rd(8'h24);
        chk(resp, `RESP_SLVERR);
        wr(8'h24, 32'h0);
        chk(resp, `RESP_SLVERR);
    endtask
    task t_absent;
        @(posedge aclk);
        dport_present <= 1'h0;
        go(32'h0);
        chk(st[`ST_DABSENT], 1'h1);
        dport_present <= 1'h1;
        // two synchroniser stages must settle before the next command
        repeat (3) @(posedge aclk);
    endtask
    task t_dtag;
        slow <= 1'h1;
        wr(`REG_PADDR, {PA, 10'h000});
        wr(`REG_INDEX, 32'h00000024);
        wr(`REG_TAG_LOW_REGISTER, {8'h00, TAG});
        wr(`REG_WDATA, 32'h5A6B7C8D);
        go(32'h2);
        go(32'h6);
        go(32'h0);
        chk(st[`ST_DHIT], 1'h1);
        rd(`REG_DRDATA);
        chk(rword, 32'h5A6B7C8D);
        wr(`REG_WDATA, 32'h01020304);
        wr(`REG_BYTEEN, 32'h5);
        go(32'h2);
        go(32'h0);
        rd(`REG_DRDATA);
        chk(rword, 32'h5A027C04);
        wr(`REG_TAG_LOW_REGISTER, 32'h0);
        go(32'h4);
        rd(`REG_TAG_LOW_REGISTER);
        chk(rword, {8'h00, TAG});
        wr(`REG_PADDR, 32'h0);
        go(32'h0);
        chk(st[`ST_DHIT], 1'h0);
        rd(`REG_DRDATA);
        chk(rword, 32'h0);
    endtask
    task t_iport;
        slow <= 1'h0;
        wr(`REG_PADDR, {PA, 10'h000});
        wr(`REG_TAG_LOW_REGISTER, {8'h00, TAG});
        wr(`REG_WDATA, 32'hC0FFEE11);
        go(32'h7);
        go(32'h3);
        go(32'h1);
        chk(st[`ST_IHIT], 1'h1);
        rd(`REG_IRDATA);
        chk(rword, 32'hC0FFEE11);
        rd(`REG_DRDATA);
        chk(rword, 32'h0);
        wr(`REG_TAG_LOW_REGISTER, 32'h0);
        go(32'h5);
        rd(`REG_TAG_LOW_REGISTER);
        chk(rword, {8'h00, TAG});
    endtask
    task close_out;
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_absent;
        t_dtag;
        t_iport;
        close_out;
    end
    initial begin
        #100000;
        num_errors++;
        close_out;
    end
endmodule
bind scratchpad_ram_port scratchpad_ram_port_sva u_scratchpad_ram_port_sva (.*);
